// >>> hdl/amd_pkg.sv
package amd_pkg;

  // How it works
  // - seventeen operand addressing modes in seven families are decoded
  // - inherent instructions are one byte, no operand fetch at all
  // - immediate takes one value byte, used as is, no memory access
  // - short direct fetches one address byte, page zero only
  // - long direct fetches a two byte address word, full 64 KB
  // - indexed address is unsigned sum of index register and offset
  // - indexed without offset fetches nothing, index alone is the address
  // - short indexed adds one offset byte, reaches up to 1FE, no wrap
  // - long indexed adds index to a two byte offset word
  // - short indirect reads a byte pointer from page zero
  // - long indirect modes read a word pointer via one address byte
  // - indirect indexed adds index to the pointer read from page zero
  // - short indirect indexed byte pointer plus index reaches 00 to 1FE
  // - memory to memory operations refuse the four long modes and accept all others
  // - long modes cost extra bytes and cycles but reach 64 KB
  // - set mask raises interrupt level to 3, clear mask lowers to 0
  // - relative modes add a signed 8-bit offset to the program counter
  // - relative indirect reads its offset from memory via pointer byte

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [4:0] {
    AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX_0, AM_IDX_S, AM_IDX_L,
    AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L, AM_REL_D, AM_REL_I,
    AM_BIT_D, AM_BIT_I, AM_BTR_D, AM_BTR_I
  } amd_mode_t;

  typedef enum logic [1:0] {
    INH_OTHER, SET_INT_MASK_INSTR, CLEAR_INT_MASK_INSTR, WAIT_FOR_IRQ_INSTR
  } amd_inh_t;

  typedef struct packed {
    amd_mode_t mode;
    logic use_y;
    logic mem2mem;
    amd_inh_t inh;
    logic [2:0] bit_num;
    logic [15:0] pc;
    logic [7:0] idx_x;
    logic [7:0] idx_y;
  } amd_req_t;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] target;
    logic [7:0] operand;
    logic [7:0] bit_mask;
    logic [1:0] len;
    logic illegal;
  } amd_res_t;

  // -----------------------------------------------------------------
  // constants
  // -----------------------------------------------------------------
  localparam logic [7:0] PAGE0_HI = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BIT_ONE = 8'h01;
  localparam logic [1:0] INT_LVL_SET = 2'h3;
  localparam logic [1:0] INT_LVL_CLR = 2'h0;
  localparam logic [1:0] INT_LVL_RST = 2'h3;

endpackage

// >>> hdl/amd_decoder.sv
`timescale 1ns/100ps
`default_nettype none

module amd_decoder
  import amd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire amd_req_t req_data_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  output logic busy_o,
  output logic rd_req_o,
  output logic [15:0] rd_addr_o,
  output logic done_o,
  output amd_res_t res_o,
  output logic [1:0] int_level_o,
  output logic wfi_o
);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_PTR, ST_DONE} amd_state_t;

  // bytes that follow the opcode in the stream
  function automatic logic [1:0] stream_len(input amd_mode_t m);
    logic [1:0] n;
    n = 2'h0;
    unique case (m)
      AM_INH, AM_IDX_0: n = 2'h0;
      AM_IMM, AM_DIR_S, AM_IDX_S: n = 2'h1;
      AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L: n = 2'h1;
      AM_REL_D, AM_REL_I, AM_BIT_D, AM_BIT_I: n = 2'h1;
      // long direct and long indexed forms and bit relative cost an extra byte
      AM_DIR_L, AM_IDX_L, AM_BTR_D, AM_BTR_I: n = 2'h2;
      default: n = 2'h0;
    endcase
    return n;
  endfunction
  // bytes of pointer read from page zero
  function automatic logic [1:0] ptr_len(input amd_mode_t m);
    logic [1:0] n;
    n = 2'h0;
    unique case (m)
      AM_IND_S, AM_IIX_S, AM_REL_I, AM_BIT_I, AM_BTR_I: n = 2'h1;
      AM_IND_L, AM_IIX_L: n = 2'h2;
      default: n = 2'h0;
    endcase
    return n;
  endfunction

  // zero extended 8-bit index, unsigned sum
  function automatic logic [15:0] idx_add(input logic [15:0] base,
                                          input logic [7:0] idx);
    logic [15:0] s;
    s = base + {PAGE0_HI, idx};
    return s;
  endfunction

  // signed 8-bit offset on the program counter
  function automatic logic [15:0] rel_add(input logic [15:0] pc,
                                          input logic [7:0] off);
    logic [15:0] s;
    s = pc + {{8{off[7]}}, off};
    return s;
  endfunction

  function automatic logic [15:0] page0(input logic [7:0] a);
    return {PAGE0_HI, a};
  endfunction

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  amd_state_t state_ff;
  amd_state_t nxt_state;
  amd_req_t req_ff;
  logic [15:0] pc_ff;
  logic [1:0] cnt_ff;
  logic [1:0] pcnt_ff;
  logic [7:0] sbuf_ff [0:1];
  logic [7:0] pbuf_ff [0:1];
  logic rd_req_ff;
  logic nxt_rd_req;
  logic [15:0] rd_addr_ff;
  logic [15:0] nxt_rd_addr;
  logic done_ff;
  amd_res_t res_ff;
  amd_res_t nxt_res;
  logic [1:0] int_lvl_ff;
  logic wfi_ff;
  logic busy_ff;
  logic beat;
  logic take;
  logic bad_req;
  logic bad_ff;
  logic [7:0] ptr_base;
  logic [7:0] idx_sel;

  assign beat = rd_req_ff && rd_valid_i;
  assign take = (state_ff == ST_IDLE) && req_i;
  assign idx_sel = req_ff.use_y ? req_ff.idx_y : req_ff.idx_x;
  // pointer address is always the first stream byte
  assign ptr_base = (cnt_ff == 2'h0) ? rd_data_i : sbuf_ff[0];

  // memory to memory only with short modes
  assign bad_req = req_data_i.mem2mem &&
    (req_data_i.mode inside {AM_DIR_L, AM_IDX_L, AM_IND_L, AM_IIX_L});

  // -----------------------------------------------------------------
  // sequencing
  // -----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_rd_addr = rd_addr_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (req_i)
        begin
          nxt_rd_addr = req_data_i.pc;
          if (bad_req || stream_len(req_data_i.mode) == 2'h0)
            nxt_state = ST_DONE;
          else
            nxt_state = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        if (beat)
        begin
          nxt_rd_addr = pc_ff + 16'h0001;
          if (cnt_ff + 2'h1 == stream_len(req_ff.mode))
          begin
            if (ptr_len(req_ff.mode) != 2'h0)
            begin
              nxt_rd_addr = page0(ptr_base);
              nxt_state = ST_PTR;
            end
            else
              nxt_state = ST_DONE;
          end
        end
      end
      ST_PTR:
      begin
        if (beat)
        begin
          nxt_rd_addr = page0(rd_addr_ff[7:0] + 8'h01);
          if (pcnt_ff + 2'h1 == ptr_len(req_ff.mode))
            nxt_state = ST_DONE;
        end
      end
      ST_DONE:
        nxt_state = ST_IDLE;
    endcase
  end

  assign nxt_rd_req = (nxt_state == ST_FETCH) || (nxt_state == ST_PTR);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_req_ff <= 1'b0;
      rd_addr_ff <= WORD_RST;
      busy_ff <= 1'b0;
    end
    else
    begin
      rd_req_ff <= nxt_rd_req;
      rd_addr_ff <= nxt_rd_addr;
      busy_ff <= nxt_state != ST_IDLE;
    end
  end

  // -----------------------------------------------------------------
  // capture of request and bytes
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      req_ff <= '0;
      bad_ff <= 1'b0;
    end
    else if (take)
    begin
      req_ff <= req_data_i;
      bad_ff <= bad_req;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pc_ff <= WORD_RST;
      cnt_ff <= 2'h0;
      pcnt_ff <= 2'h0;
    end
    else if (take)
    begin
      pc_ff <= req_data_i.pc;
      cnt_ff <= 2'h0;
      pcnt_ff <= 2'h0;
    end
    else if (beat && state_ff == ST_FETCH)
    begin
      pc_ff <= pc_ff + 16'h0001;
      cnt_ff <= cnt_ff + 2'h1;
    end
    else if (beat && state_ff == ST_PTR)
      pcnt_ff <= pcnt_ff + 2'h1;
  end

  // stream and pointer bytes, high byte first for words
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sbuf_ff[0] <= BYTE_RST;
      sbuf_ff[1] <= BYTE_RST;
      pbuf_ff[0] <= BYTE_RST;
      pbuf_ff[1] <= BYTE_RST;
    end
    else if (beat && state_ff == ST_FETCH)
      sbuf_ff[cnt_ff[0]] <= rd_data_i;
    else if (beat && state_ff == ST_PTR)
      pbuf_ff[pcnt_ff[0]] <= rd_data_i;
  end

  // -----------------------------------------------------------------
  // effective address forming
  // -----------------------------------------------------------------
  always_comb
  begin
    nxt_res = '0;
    nxt_res.len = bad_ff ? 2'h0 : stream_len(req_ff.mode);
    nxt_res.illegal = bad_ff;
    nxt_res.bit_mask = BIT_ONE << req_ff.bit_num;
    nxt_res.target = pc_ff;
    unique case (req_ff.mode)
      AM_INH:
        nxt_res.ea = WORD_RST;
      AM_IMM:
        nxt_res.operand = sbuf_ff[0];
      AM_DIR_S, AM_BIT_D, AM_BTR_D:
        nxt_res.ea = page0(sbuf_ff[0]);
      AM_DIR_L:
        nxt_res.ea = {sbuf_ff[0], sbuf_ff[1]};
      AM_IDX_0:
        nxt_res.ea = page0(idx_sel);
      AM_IDX_S:
        nxt_res.ea = idx_add(page0(sbuf_ff[0]), idx_sel);
      AM_IDX_L:
        nxt_res.ea = idx_add({sbuf_ff[0], sbuf_ff[1]}, idx_sel);
      AM_IND_S, AM_BIT_I, AM_BTR_I:
        nxt_res.ea = page0(pbuf_ff[0]);
      AM_IND_L:
        nxt_res.ea = {pbuf_ff[0], pbuf_ff[1]};
      AM_IIX_S:
        nxt_res.ea = idx_add(page0(pbuf_ff[0]), idx_sel);
      AM_IIX_L:
        nxt_res.ea = idx_add({pbuf_ff[0], pbuf_ff[1]}, idx_sel);
      AM_REL_D:
      begin
        nxt_res.operand = sbuf_ff[0];
        nxt_res.target = rel_add(pc_ff, sbuf_ff[0]);
      end
      AM_REL_I:
      begin
        nxt_res.operand = pbuf_ff[0];
        nxt_res.target = rel_add(pc_ff, pbuf_ff[0]);
      end
      default:
        nxt_res.illegal = 1'b1;
    endcase
    // bit relative: second stream byte is the branch offset
    if (req_ff.mode inside {AM_BTR_D, AM_BTR_I})
    begin
      nxt_res.operand = sbuf_ff[1];
      nxt_res.target = rel_add(pc_ff, sbuf_ff[1]);
    end
    // refused request fetched nothing; report no bytes
    if (bad_ff)
      nxt_res.ea = WORD_RST;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done_ff <= 1'b0;
      res_ff <= '0;
    end
    else
    begin
      done_ff <= state_ff == ST_DONE;
      if (state_ff == ST_DONE)
        res_ff <= nxt_res;
    end
  end

  // -----------------------------------------------------------------
  // interrupt level and wait
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      int_lvl_ff <= INT_LVL_RST;
      wfi_ff <= 1'b0;
    end
    else
    begin
      wfi_ff <= 1'b0;
      if (state_ff == ST_DONE && req_ff.mode == AM_INH)
      begin
        if (req_ff.inh == SET_INT_MASK_INSTR)
          int_lvl_ff <= INT_LVL_SET;
        else if (req_ff.inh == CLEAR_INT_MASK_INSTR)
          int_lvl_ff <= INT_LVL_CLR;
        wfi_ff <= req_ff.inh == WAIT_FOR_IRQ_INSTR;
      end
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign busy_o = busy_ff;
  assign rd_req_o = rd_req_ff;
  assign rd_addr_o = rd_addr_ff;
  assign done_o = done_ff;
  assign res_o = res_ff;
  assign int_level_o = int_lvl_ff;
  assign wfi_o = wfi_ff;

endmodule

`default_nettype wire

// >>> verification/amd_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module amd_mem_model
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rd_req_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic [1:0] dly_i,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o
);
  // ------
  // memory
  // ------
  logic [1:0] cnt_ff;
  logic [7:0] last_ff;
  // released bus shows the inverse byte, never a stale copy
  assign rd_valid_o = rd_req_i && (cnt_ff >= dly_i);
  assign rd_data_o = rd_valid_o ? (rd_addr_i[7:0] ^ rd_addr_i[15:8]) : ~last_ff;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff <= 2'h0;
      last_ff <= 8'h00;
    end
    else if (rd_valid_o)
    begin
      cnt_ff <= 2'h0;
      last_ff <= rd_data_o;
    end
    else if (rd_req_i)
      cnt_ff <= cnt_ff + 2'h1;
  end
endmodule
`default_nettype wire

// >>> verification/amd_decoder_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module amd_decoder_checker
  import amd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire amd_req_t req_data_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  input wire logic busy_o,
  input wire logic rd_req_o,
  input wire logic [15:0] rd_addr_o,
  input wire logic done_o,
  input wire amd_res_t res_o,
  input wire logic [1:0] int_level_o,
  input wire logic wfi_o
);
  // ------
  // helpers
  // ------
  logic take;
  logic inh;
  logic lng;
  logic [7:0] idx;
  // busy low means idle, so a request there is taken
  assign take = req_i && !busy_o;
  assign inh = take && req_data_i.mode == AM_INH;
  assign lng = req_data_i.mode inside {AM_DIR_L, AM_IDX_L, AM_IND_L, AM_IIX_L};
  assign idx = req_data_i.use_y ? req_data_i.idx_y : req_data_i.idx_x;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ------
  // properties
  // ------
  property p_inh_len;
    inh |=> !rd_req_o ##1 (!rd_req_o && done_o && res_o.len == 2'h0);
  endproperty
  a_inh_len: assert property (p_inh_len)
    else $error("inherent fetched");
  property p_idx0;
    take && req_data_i.mode == AM_IDX_0 |->
      ##2 (done_o && res_o.ea == {8'h00, $past(idx, 2)});
  endproperty
  a_idx0: assert property (p_idx0)
    else $error("no offset address");
  property p_first;
    take && req_data_i.mode inside {AM_IMM, AM_DIR_S} |=>
      rd_req_o && rd_addr_o == $past(req_data_i.pc);
  endproperty
  a_first: assert property (p_first)
    else $error("first fetch address");
  property p_refuse;
    take && req_data_i.mem2mem && lng |=> !rd_req_o ##1 (!rd_req_o &&
      done_o && res_o.illegal && res_o.len == 2'h0 && res_o.ea == 16'h0000);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("long mem2mem taken");
  property p_set;
    inh && req_data_i.inh == SET_INT_MASK_INSTR |-> ##3 int_level_o == 2'h3;
  endproperty
  a_set: assert property (p_set) else $error("mask not set");
  property p_clr;
    inh && req_data_i.inh == CLEAR_INT_MASK_INSTR |-> ##3 int_level_o == 2'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("mask not cleared");
  property p_wfi;
    inh && req_data_i.inh == WAIT_FOR_IRQ_INSTR |-> ##2 (done_o && wfi_o);
  endproperty
  a_wfi: assert property (p_wfi) else $error("wfi missing");
  property p_hold;
    rd_req_o && !rd_valid_i |=> rd_req_o && $stable(rd_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read dropped");
  property p_lvl;
    $changed(int_level_o) |-> done_o;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level moved");
endmodule
bind amd_decoder amd_decoder_checker u_chk (
  .clk_i, .rst_n_i, .req_i, .req_data_i, .rd_valid_i, .rd_data_i,
  .busy_o, .rd_req_o, .rd_addr_o, .done_o, .res_o, .int_level_o, .wfi_o
);
`default_nettype wire

// >>> verification/tb_cpu_addressing_mode_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_addressing_mode_decoder;
  import amd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  amd_req_t req_data_i = '0;
  logic rd_valid_i;
  logic [7:0] rd_data_i;
  logic busy_o;
  logic rd_req_o;
  logic [15:0] rd_addr_o;
  logic done_o;
  amd_res_t res_o;
  logic [1:0] int_level_o;
  logic wfi_o;
  logic [1:0] dly = 2'h0;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #12.5 clk_i = ~clk_i;
  amd_decoder dut (
    .clk_i, .rst_n_i, .req_i, .req_data_i, .rd_valid_i, .rd_data_i,
    .busy_o, .rd_req_o, .rd_addr_o, .done_o, .res_o, .int_level_o, .wfi_o
  );
  amd_mem_model mem (
    .clk_i, .rst_n_i, .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o),
    .dly_i(dly), .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i)
  );
  // ------
  // helpers
  // ------
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  function automatic logic [15:0] sx(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // waits on done under a bound; slow memory needs about 13 cycles
  task automatic issue(input amd_req_t r);
    int n;
    @(posedge clk_i);
    req_data_i <= r;
    req_i <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    #1;
    chk("busy", 16'h0001, 16'(busy_o));
    n = 0;
    while (done_o !== 1'b1 && n < 60)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("done", 16'h0001, 16'(done_o));
    chk("busy", 16'h0000, 16'(busy_o));
  endtask
  // ------
  // scenarios
  // ------
  task automatic test_reset;
    chk("level", 16'h0003, 16'(int_level_o));
    chk("idle", 16'h0000, 16'({busy_o, rd_req_o, done_o, wfi_o}));
  endtask
  task automatic test_inh;
    amd_req_t r;
    amd_inh_t ks [3] = '{CLEAR_INT_MASK_INSTR, SET_INT_MASK_INSTR,
      WAIT_FOR_IRQ_INSTR};
    r = '0;
    foreach (ks[i])
    begin
      r.inh = ks[i];
      issue(r);
      chk("level", (i == 0) ? 16'h0000 : 16'h0003, 16'(int_level_o));
      chk("wfi", 16'(i == 2), 16'(wfi_o));
    end
  endtask
  task automatic test_modes(input logic [15:0] pc, input logic [7:0] ix,
    input logic us, input logic [1:0] d);
    amd_req_t r;
    logic [7:0] b0, b1, p0, p1;
    logic [15:0] ea, tg;
    logic [1:0] ln;
    logic ce;
    int lens [17] = '{0, 1, 1, 2, 0, 1, 2, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2};
    dly = d;
    r = '0;
    r.pc = pc;
    r.use_y = us;
    // the unused index holds the inverse so a wrong pick shows
    r.idx_x = us ? ~ix : ix;
    r.idx_y = us ? ix : ~ix;
    b0 = mb(pc);
    b1 = mb(pc + 16'h0001);
    p0 = mb({8'h00, b0});
    p1 = mb({8'h00, b0 + 8'h01});
    for (int i = 0; i < 17; i++)
    begin
      r.mode = amd_mode_t'(i);
      r.bit_num = i[2:0];
      ln = 2'(lens[i]);
      ce = 1'b1;
      tg = pc + 16'(ln);
      case (r.mode)
        AM_DIR_S, AM_BIT_D, AM_BTR_D: ea = {8'h00, b0};
        AM_DIR_L: ea = {b0, b1};
        AM_IDX_0: ea = {8'h00, ix};
        AM_IDX_S: ea = {8'h00, b0} + {8'h00, ix};
        AM_IDX_L: ea = {b0, b1} + {8'h00, ix};
        AM_IND_S, AM_BIT_I, AM_BTR_I: ea = {8'h00, p0};
        AM_IND_L: ea = {p0, p1};
        AM_IIX_S: ea = {8'h00, p0} + {8'h00, ix};
        AM_IIX_L: ea = {p0, p1} + {8'h00, ix};
        default: ce = 1'b0;
      endcase
      if (r.mode == AM_REL_D)
        tg = tg + sx(b0);
      if (r.mode == AM_REL_I)
        tg = tg + sx(p0);
      if (r.mode inside {AM_BTR_D, AM_BTR_I})
        tg = tg + sx(b1);
      issue(r);
      chk("illegal", 16'h0000, 16'(res_o.illegal));
      chk("len", 16'(ln), 16'(res_o.len));
      chk("target", tg, res_o.target);
      chk("bit_mask", 16'(8'h01 << i[2:0]), 16'(res_o.bit_mask));
      if (ce)
        chk("ea", ea, res_o.ea);
      if (r.mode == AM_IMM)
        chk("operand", 16'(b0), 16'(res_o.operand));
    end
  endtask
  task automatic test_refuse;
    amd_req_t r;
    amd_mode_t ms [4] = '{AM_DIR_L, AM_IDX_L, AM_IND_L, AM_IIX_L};
    r = '0;
    r.mem2mem = 1'b1;
    r.pc = 16'h0400;
    foreach (ms[i])
    begin
      r.mode = ms[i];
      issue(r);
      chk("illegal", 16'h0001, 16'(res_o.illegal));
      chk("ea", 16'h0000, res_o.ea);
      chk("len", 16'h0000, 16'(res_o.len));
    end
    r.mode = AM_DIR_S;
    issue(r);
    chk("ea", {8'h00, mb(16'h0400)}, res_o.ea);
    // an unused mode code must come back flagged, with nothing fetched
    r.mode = amd_mode_t'(5'h11);
    issue(r);
    chk("illegal", 16'h0001, 16'(res_o.illegal));
    chk("len", 16'h0000, 16'(res_o.len));
  endtask
  // ------
  // main
  // ------
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      bad_count++;
      $display("mismatch timeout expected done seen hang");
      stop_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    test_reset();
    test_inh();
    test_modes(16'h10ef, 8'hff, 1'b0, 2'h0);
    test_modes(16'h2345, 8'h12, 1'b1, 2'h3);
    test_refuse();
    stop_test();
  end
endmodule
`default_nettype wire
